// >>> verilog/arc_adc_result_ctrl.sv
// Converter result registers, auto trigger selection and analog pin input disable
// Assumes a same-clock register master with one-cycle strobes and a conversion engine on i_sys_clk
`timescale 1ns/1ps
`include "arc_map.svh"

module arc_adc_result_ctrl (
  input  wire logic                  i_sys_clk,
  input  wire logic                  i_sys_rst,
  input  wire logic [7:0]            i_addr,
  input  wire logic [7:0]            i_wdata,
  input  wire logic                  i_wr,
  input  wire logic                  i_rd,
  output logic      [7:0]            o_rdata,
  input  wire arc_pkg::arc_conv_s    i_conv,
  input  wire arc_pkg::arc_ctrl_s    i_ctrl,
  input  wire logic                  i_done_flag_clear,
  input  wire arc_pkg::arc_trig_src_s i_trig_src,
  input  wire logic [5:0]            i_pin_level,
  output logic                       o_conversion_done_flag,
  output logic                       o_auto_trigger_start,
  output logic                       o_comparator_mux_enable,
  output logic      [5:0]            o_pin_input_buffer_off,
  output logic      [5:0]            o_port_input
);
  import arc_pkg::*;

  // Presents the stored value as high and low bytes
  function automatic logic [15:0] present_result(input logic [9:0] value, input logic left);
    if (left) begin
      present_result = {value, 6'h00};
    end else begin
      present_result = {6'h00, value};
    end
  endfunction

  // Result store and lock
  logic [9:0]  conversion_value;
  logic        result_locked;
  logic [9:0]  next_conversion_value;
  logic        next_result_locked;
  logic        rd_low;
  logic        rd_high;

  // Software visible control
  arc_trig_t   trigger_source_select;
  logic        comparator_mux_enable;
  logic [5:0]  pin_input_buffer_off;
  arc_trig_t   next_trigger_source_select;
  logic        next_comparator_mux_enable;
  logic [5:0]  next_pin_input_buffer_off;

  // Flag, read data and pin path
  logic        conversion_done_flag;
  logic        next_conversion_done_flag;
  logic [7:0]  next_rdata;
  logic [15:0] shown;
  logic [5:0]  pin_meta;
  logic [5:0]  pin_sync;
  logic [5:0]  next_port_input;

  logic [7:0]  trig_sources;
  logic        trig_armed;
  logic        trig_start;

  assign rd_low  = i_rd && (i_addr == `ARC_OFS_RESULT_LOW);
  assign rd_high = i_rd && (i_addr == `ARC_OFS_RESULT_HIGH);

  // Result store and lock
  always_comb begin
    next_conversion_value = conversion_value;
    next_result_locked    = result_locked;
    // A low read in the same cycle also blocks the update, keeping the pair coherent
    if (i_conv.done && !result_locked && !rd_low) begin
      next_conversion_value = i_conv.value;
    end
    if (rd_low) begin
      next_result_locked = 1'b1;
    end else if (rd_high) begin
      next_result_locked = 1'b0;
    end
  end

  always_ff @(posedge i_sys_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      conversion_value <= `ARC_RST_RESULT;
      result_locked    <= 1'b0;
    end else begin
      conversion_value <= next_conversion_value;
      result_locked    <= next_result_locked;
    end
  end

  // Done flag, set wins over clear
  always_comb begin
    next_conversion_done_flag = conversion_done_flag;
    if (i_done_flag_clear) begin
      next_conversion_done_flag = 1'b0;
    end
    if (i_conv.done) begin
      next_conversion_done_flag = 1'b1;
    end
  end

  always_ff @(posedge i_sys_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      conversion_done_flag <= 1'b0;
    end else begin
      conversion_done_flag <= next_conversion_done_flag;
    end
  end

  // Register writes; result registers take none
  always_comb begin
    next_trigger_source_select = trigger_source_select;
    next_comparator_mux_enable = comparator_mux_enable;
    next_pin_input_buffer_off  = pin_input_buffer_off;
    if (i_wr) begin
      unique case (i_addr)
        `ARC_OFS_TRIGGER_CTRL: begin
          next_trigger_source_select = i_wdata[`ARC_TRG_SEL_MSB:`ARC_TRG_SEL_LSB];
          next_comparator_mux_enable = i_wdata[`ARC_TRG_CMP_MUX_BIT];
        end
        `ARC_OFS_INPUT_DISABLE: begin
          next_pin_input_buffer_off = i_wdata[`ARC_DIS_MSB:0];
        end
        default: begin
          next_trigger_source_select = trigger_source_select;
        end
      endcase
    end
  end

  always_ff @(posedge i_sys_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      trigger_source_select <= arc_trig_t'(`ARC_RST_TRIGGER_CTRL);
      comparator_mux_enable <= 1'b0;
      pin_input_buffer_off  <= `ARC_RST_INPUT_DISABLE;
    end else begin
      trigger_source_select <= next_trigger_source_select;
      comparator_mux_enable <= next_comparator_mux_enable;
      pin_input_buffer_off  <= next_pin_input_buffer_off;
    end
  end

  // Read data, one cycle after the strobe
  always_comb begin
    shown      = present_result(conversion_value, i_ctrl.result_left_align);
    next_rdata = `ARC_RST_BYTE;
    if (i_rd) begin
      unique case (i_addr)
        `ARC_OFS_RESULT_LOW:    next_rdata = shown[7:0];
        `ARC_OFS_RESULT_HIGH:   next_rdata = shown[15:8];
        `ARC_OFS_TRIGGER_CTRL:  next_rdata = {1'b0, comparator_mux_enable, 3'h0, trigger_source_select};
        `ARC_OFS_INPUT_DISABLE: next_rdata = {2'h0, pin_input_buffer_off};
        default:                next_rdata = `ARC_RST_BYTE;
      endcase
    end
  end

  always_ff @(posedge i_sys_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_rdata <= `ARC_RST_BYTE;
    end else begin
      o_rdata <= next_rdata;
    end
  end

  // Pin inputs synchronised, then gated by the disable bits
  always_comb begin
    next_port_input = pin_sync & ~pin_input_buffer_off;
  end

  always_ff @(posedge i_sys_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      pin_meta     <= 6'h00;
      pin_sync     <= 6'h00;
      o_port_input <= 6'h00;
    end else begin
      pin_meta     <= i_pin_level;
      pin_sync     <= pin_meta;
      o_port_input <= next_port_input;
    end
  end

  // Trigger source vector indexed by select code; code 0 is the done flag
  assign trig_sources = {i_trig_src.t1_capture, i_trig_src.t1_ovf, i_trig_src.t1_cmp_b,
                         i_trig_src.t0_ovf, i_trig_src.t0_cmp_a, i_trig_src.ext_int0,
                         i_trig_src.comparator, conversion_done_flag};
  assign trig_armed   = i_ctrl.auto_trigger_enable && i_ctrl.converter_enable;

  arc_trigger_edge u_trigger_edge (
    .i_sys_clk               (i_sys_clk),
    .i_sys_rst               (i_sys_rst),
    .i_trigger_source_select (trigger_source_select),
    .i_sources               (trig_sources),
    .i_armed                 (trig_armed),
    .o_start                 (trig_start)
  );

  // Outputs from flip-flops
  assign o_conversion_done_flag  = conversion_done_flag;
  assign o_auto_trigger_start    = trig_start;
  assign o_comparator_mux_enable = comparator_mux_enable;
  assign o_pin_input_buffer_off  = pin_input_buffer_off;

endmodule

// >>> verilog/arc_map.svh
// Register map, field positions, reset values and trigger codes of the converter result block
// Assumes inclusion by bare name from the package and the design modules
`ifndef ARC_MAP_SVH
`define ARC_MAP_SVH

// Register offsets in data space
`define ARC_OFS_RESULT_LOW      8'h78
`define ARC_OFS_RESULT_HIGH     8'h79
`define ARC_OFS_TRIGGER_CTRL    8'h7B
`define ARC_OFS_INPUT_DISABLE   8'h7E

// Reset values
`define ARC_RST_RESULT          10'h000
`define ARC_RST_TRIGGER_CTRL    8'h00
`define ARC_RST_INPUT_DISABLE   6'h00
`define ARC_RST_BYTE            8'h00

// Trigger control fields
`define ARC_TRG_SEL_LSB         0
`define ARC_TRG_SEL_MSB         2
`define ARC_TRG_CMP_MUX_BIT     6

// Input disable field
`define ARC_DIS_MSB             5

// Trigger source codes
`define ARC_TRG_FREE_RUN        3'h0
`define ARC_TRG_COMPARATOR      3'h1
`define ARC_TRG_EXT_INT0        3'h2
`define ARC_TRG_T0_CMP_A        3'h3
`define ARC_TRG_T0_OVF          3'h4
`define ARC_TRG_T1_CMP_B        3'h5
`define ARC_TRG_T1_OVF          3'h6
`define ARC_TRG_T1_CAPTURE      3'h7

`endif

// >>> verilog/arc_pkg.sv
// Types shared by the converter result block
// Assumes arc_map.svh is on the include path
`include "arc_map.svh"

package arc_pkg;

  typedef logic [2:0] arc_trig_t;

  // Handshake from the conversion engine
  typedef struct packed {
    logic       done;
    logic [9:0] value;
  } arc_conv_s;

  // Control bits held in the converter's other registers
  typedef struct packed {
    logic converter_enable;
    logic auto_trigger_enable;
    logic result_left_align;
  } arc_ctrl_s;

  // Peripheral event flags, bit n is trigger code n+1, code 0 has no flag here
  typedef struct packed {
    logic t1_capture;
    logic t1_ovf;
    logic t1_cmp_b;
    logic t0_ovf;
    logic t0_cmp_a;
    logic ext_int0;
    logic comparator;
  } arc_trig_src_s;

endpackage

// >>> verilog/arc_trigger_edge.sv
// Auto trigger source selector with rising edge detection
// Assumes all source flags come from logic on the same clock
`timescale 1ns/1ps
`include "arc_map.svh"

module arc_trigger_edge (
  input  wire logic             i_sys_clk,
  input  wire logic             i_sys_rst,
  input  wire arc_pkg::arc_trig_t i_trigger_source_select,
  input  wire logic [7:0]       i_sources,
  input  wire logic             i_armed,
  output logic                  o_start
);
  import arc_pkg::*;

  logic      sel_level;
  logic      prev_level;
  arc_trig_t prev_select;
  logic      to_free_run;
  logic      next_prev_level;
  arc_trig_t next_prev_select;
  logic      next_start;

  always_comb begin
    sel_level        = i_sources[i_trigger_source_select];
    to_free_run      = (i_trigger_source_select == `ARC_TRG_FREE_RUN) &&
                       (prev_select != `ARC_TRG_FREE_RUN);
    next_prev_level  = sel_level;
    next_prev_select = i_trigger_source_select;
    // Edge also arises when switching from a clear to a set source other than free run
    next_start       = i_armed && sel_level && !prev_level && !to_free_run;
  end

  always_ff @(posedge i_sys_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      prev_level  <= 1'b0;
      prev_select <= `ARC_TRG_FREE_RUN;
      o_start     <= 1'b0;
    end else begin
      prev_level  <= next_prev_level;
      prev_select <= next_prev_select;
      o_start     <= next_start;
    end
  end

endmodule

// >>> testbench/arc_adc_result_ctrl_asserts.sv
// Port-level checks for the converter result block
// Assumes a bind into arc_adc_result_ctrl with one clock domain
`timescale 1ns/1ps

module arc_chk (
  input wire logic               i_sys_clk,
  input wire logic               i_sys_rst,
  input wire logic [7:0]         i_addr,
  input wire logic               i_rd,
  input wire logic [7:0]         o_rdata,
  input wire arc_pkg::arc_conv_s i_conv,
  input wire arc_pkg::arc_ctrl_s i_ctrl,
  input wire logic               i_done_flag_clear,
  input wire logic               o_conversion_done_flag,
  input wire logic               o_auto_trigger_start,
  input wire logic [5:0]         o_pin_input_buffer_off,
  input wire logic [5:0]         o_port_input
);
  import arc_pkg::*;
  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (i_sys_rst);

  flag_set_a: assert property (i_conv.done |=> o_conversion_done_flag)
    else $error("flag not set");
  flag_clear_a: assert property (i_done_flag_clear && !i_conv.done |=> !o_conversion_done_flag)
    else $error("flag not cleared");
  start_width_a: assert property ($rose(o_auto_trigger_start) |=> $fell(o_auto_trigger_start))
    else $error("start pulse too long");
  start_unarmed_a: assert property (!(i_ctrl.converter_enable && i_ctrl.auto_trigger_enable)
    |=> !o_auto_trigger_start)
    else $error("start while unarmed");
  port_forced_a: assert property ((o_port_input & $past(o_pin_input_buffer_off)) == 6'h00)
    else $error("disabled pin reads one");
  trig_rsvd_a: assert property ($past(i_rd) && $past(i_addr) == 8'h7B |-> (o_rdata & 8'hB8) == 8'h00)
    else $error("trigger reserved bits set");
  dis_rsvd_a: assert property ($past(i_rd) && $past(i_addr) == 8'h7E |-> (o_rdata & 8'hC0) == 8'h00)
    else $error("disable reserved bits set");
  right_pad_a: assert property ($past(i_rd) && $past(i_addr) == 8'h79 && !$past(i_ctrl.result_left_align)
    |-> (o_rdata & 8'hFC) == 8'h00)
    else $error("right aligned high byte padding");
  left_pad_a: assert property ($past(i_rd) && $past(i_addr) == 8'h78 && $past(i_ctrl.result_left_align)
    |-> (o_rdata & 8'h3F) == 8'h00)
    else $error("left aligned low byte padding");

  cover property (o_auto_trigger_start);
  cover property (i_done_flag_clear && o_conversion_done_flag);
  cover property (i_rd && i_addr == 8'h79);
endmodule

// >>> testbench/arc_conv_model.sv
// Conversion engine model facing the result block
// Assumes the same clock and reset as the block
`timescale 1ns/1ps

module arc_conv_model #(
  parameter int LAT = 3
) (
  input  wire logic          i_sys_clk,
  input  wire logic          i_sys_rst,
  input  wire logic          i_start,
  input  wire logic [9:0]    i_value,
  output arc_pkg::arc_conv_s o_conv
);
  import arc_pkg::*;
  int         cnt;
  logic [9:0] val;

  // Done pulses LAT cycles after a start, value churns outside it
  always_ff @(posedge i_sys_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      cnt    <= 0;
      val    <= '0;
      o_conv <= '0;
    end else begin
      o_conv.done  <= (cnt == 1);
      o_conv.value <= (cnt == 1) ? val : ~o_conv.value;
      if (i_start) begin
        cnt <= LAT;
        val <= i_value;
      end else if (cnt != 0) begin
        cnt <= cnt - 1;
      end
    end
  end
endmodule

// >>> testbench/test_adc_result_trigger_pin_disable.sv
// Self-checking bench for the converter result block
// Assumes the block, its checker and the conversion model are compiled
`timescale 1ns/1ps

module test_adc_result_trigger_pin_disable;
  import arc_pkg::*;
  localparam int LAT = 3;
  logic          i_sys_clk, i_sys_rst, i_wr, i_rd, i_done_flag_clear, go, flag, start, mux;
  logic [7:0]    i_addr, i_wdata, o_rdata, d;
  logic [5:0]    i_pin_level, buf_off, port_in;
  logic [9:0]    val;
  arc_conv_s     conv;
  arc_ctrl_s     i_ctrl;
  arc_trig_src_s i_trig_src;
  int            fails, n_checks, n_start;

  arc_adc_result_ctrl dut (.i_sys_clk(i_sys_clk), .i_sys_rst(i_sys_rst), .i_addr(i_addr), .i_wdata(i_wdata),
    .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_conv(conv), .i_ctrl(i_ctrl),
    .i_done_flag_clear(i_done_flag_clear), .i_trig_src(i_trig_src), .i_pin_level(i_pin_level),
    .o_conversion_done_flag(flag), .o_auto_trigger_start(start), .o_comparator_mux_enable(mux),
    .o_pin_input_buffer_off(buf_off), .o_port_input(port_in));
  arc_conv_model #(.LAT(LAT)) u_conv (.i_sys_clk(i_sys_clk), .i_sys_rst(i_sys_rst), .i_start(go | start),
    .i_value(val), .o_conv(conv));

  task chk(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp) begin
      fails++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge i_sys_clk);
    i_wr    <= 1'b1;
    i_addr  <= a;
    i_wdata <= v;
    @(posedge i_sys_clk);
    i_wr <= 1'b0;
  endtask
  task rd(input logic [7:0] a);
    @(posedge i_sys_clk);
    i_rd   <= 1'b1;
    i_addr <= a;
    @(posedge i_sys_clk);
    i_rd <= 1'b0;
    #1 d = o_rdata;
  endtask
  task rpair(input logic [7:0] lo, input logic [7:0] hi);
    rd(8'h78);
    chk(d, lo);
    rd(8'h79);
    chk(d, hi);
  endtask
  task conv_go(input logic [9:0] v);
    @(posedge i_sys_clk);
    val <= v;
    go  <= 1'b1;
    @(posedge i_sys_clk);
    go <= 1'b0;
    repeat (LAT + 2) @(posedge i_sys_clk);
  endtask
  task clr;
    @(posedge i_sys_clk);
    i_done_flag_clear <= 1'b1;
    @(posedge i_sys_clk);
    i_done_flag_clear <= 1'b0;
    #1 chk(8'(flag), 8'h00);
  endtask
  task src(input int k);
    @(posedge i_sys_clk);
    i_trig_src <= 7'(1 << (k - 1));
    repeat (2) @(posedge i_sys_clk);
    i_trig_src <= '0;
    repeat (LAT + 3) @(posedge i_sys_clk);
  endtask

  task t_reset;
    logic [7:0] a[5];
    a = '{8'h78, 8'h79, 8'h7B, 8'h7E, 8'h7F};
    foreach (a[i]) begin
      rd(a[i]);
      chk(d, 8'h00);
    end
  endtask
  task t_align;
    conv_go(10'h2D7);
    wr(8'h78, 8'hFF);
    wr(8'h79, 8'hFF);
    rpair(8'hD7, 8'h02);
    @(posedge i_sys_clk);
    i_ctrl.result_left_align <= 1'b1;
    rpair(8'hC0, 8'hB5);
    rd(8'h78);
    @(posedge i_sys_clk);
    i_ctrl.result_left_align <= 1'b0;
    rd(8'h79);
    chk(d, 8'h02);
  endtask
  task t_lock;
    conv_go(10'h155);
    rd(8'h78);
    chk(d, 8'h55);
    clr;
    conv_go(10'h2AA);
    chk(8'(flag), 8'h01);
    rd(8'h79);
    chk(d, 8'h01);
    rpair(8'h55, 8'h01);
    conv_go(10'h3FF);
    rd(8'h79);
    chk(d, 8'h03);
  endtask
  task t_pins;
    wr(8'h7E, 8'h15);
    wr(8'h7B, 8'h47);
    i_pin_level <= 6'h3F;
    repeat (4) @(posedge i_sys_clk);
    chk(8'(port_in), 8'h2A);
    chk({mux, 1'b0, buf_off}, 8'h95);
    rd(8'h7E);
    chk(d, 8'h15);
    rd(8'h7B);
    chk(d, 8'h47);
    wr(8'h7E, 8'h00);
    repeat (4) @(posedge i_sys_clk);
    chk(8'(port_in), 8'h3F);
  endtask
  task t_trig;
    int s;
    i_ctrl <= 3'b110;
    for (int c = 1; c < 8; c++) begin
      wr(8'h7B, 8'(c));
      s = n_start;
      src(c);
      chk(8'(n_start - s), 8'h01);
    end
    i_ctrl <= 3'b100;
    s = n_start;
    src(7);
    chk(8'(n_start - s), 8'h00);
    i_ctrl <= 3'b110;
    wr(8'h7B, 8'h01);
    i_trig_src <= 7'h02;
    s = n_start;
    wr(8'h7B, 8'h02);
    repeat (3) @(posedge i_sys_clk);
    chk(8'(n_start - s), 8'h01);
    repeat (LAT + 3) @(posedge i_sys_clk);
    i_trig_src <= '0;
    s = n_start;
    wr(8'h7B, 8'h00);
    repeat (3) @(posedge i_sys_clk);
    chk(8'(n_start - s), 8'h00);
    clr;
    s = n_start;
    conv_go(10'h001);
    repeat (2) @(posedge i_sys_clk);
    chk(8'(n_start - s), 8'h01);
  endtask

  task end_sim;
    $display("checks %0d errors %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  initial begin
    i_sys_clk = 1'b0;
    forever #50 i_sys_clk = ~i_sys_clk;
  end
  always @(posedge i_sys_clk) if (start) n_start++;
  initial begin
    #(100 * 4000);
    fails++;
    end_sim;
  end
  initial begin
    i_sys_rst         = 1'b1;
    {i_wr, i_rd, go}  = 3'b000;
    i_done_flag_clear = 1'b0;
    {i_addr, i_wdata} = 16'h0000;
    i_ctrl            = '0;
    i_trig_src        = '0;
    i_pin_level       = 6'h00;
    val               = 10'h000;
    repeat (20) @(posedge i_sys_clk);
    i_sys_rst <= 1'b0;
    t_reset;
    t_align;
    t_lock;
    t_pins;
    t_trig;
    end_sim;
  end
endmodule

bind arc_adc_result_ctrl arc_chk u_chk (.i_sys_clk(i_sys_clk), .i_sys_rst(i_sys_rst), .i_addr(i_addr),
  .i_rd(i_rd), .o_rdata(o_rdata), .i_conv(i_conv), .i_ctrl(i_ctrl), .i_done_flag_clear(i_done_flag_clear),
  .o_conversion_done_flag(o_conversion_done_flag), .o_auto_trigger_start(o_auto_trigger_start),
  .o_pin_input_buffer_off(o_pin_input_buffer_off), .o_port_input(o_port_input));
